// ---- design/gst_pkg.sv ----
// constants shared by the gated sixteen bit timer design files
// assumes one 50 MHz clock and a 32-bit axi4-lite register port
package gst_pkg;
  // clock figures
  localparam int unsigned GST_CLK_HZ = 50_000_000;
  localparam int unsigned GST_INST_DIV = 4;
  localparam logic [1:0] GST_INST_LAST = 2'(GST_INST_DIV - 1);
  // register byte addresses
  localparam logic [7:0] GST_ADDR_CTRL = 8'h00;
  localparam logic [7:0] GST_ADDR_CNT_LO = 8'h04;
  localparam logic [7:0] GST_ADDR_CNT_HI = 8'h08;
  localparam logic [7:0] GST_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] GST_ADDR_GATE_SRC = 8'h10;
  localparam logic [7:0] GST_ADDR_PORT = 8'h14;
  // control register fields
  localparam int GST_B_TIMER_ON = 0;
  localparam int GST_B_CLK_SEL = 1;
  localparam int GST_B_SYNC_DIS = 2;
  localparam int GST_B_OSC_EN = 3;
  localparam int GST_B_PSC_LO = 4;
  localparam int GST_B_GATE_EN = 6;
  localparam int GST_B_GATE_INV = 7;
  localparam logic [7:0] GST_CTRL_RST = 8'h00;
  // status, gate source and port fields
  localparam int GST_B_OVF = 0;
  localparam int GST_B_GATE_SRC = 1;
  localparam logic GST_GATE_SRC_RST = 1'b1;
  localparam int GST_B_PIN4_DATA = 0;
  localparam int GST_B_PIN5_DATA = 1;
  localparam int GST_B_PIN4_DIR = 4;
  localparam int GST_B_PIN5_DIR = 5;
  localparam logic GST_DIR_RST = 1'b1;
  // count values
  localparam logic [15:0] GST_CNT_MAX = 16'hffff;
  localparam logic [15:0] GST_CNT_ZERO = 16'h0000;
  // bus answers
  localparam logic [1:0] GST_RESP_OKAY = 2'b00;
  localparam logic [1:0] GST_RESP_SLVERR = 2'b10;
endpackage : gst_pkg

// ---- design/gst_prescaler.sv ----
// prescaler dividing a tick stream by 1, 2, 4 or 8
// assumes tick and clear are single-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module gst_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] select,
  output logic out_tick
);
  logic [2:0] cnt_reg;
  logic [2:0] mask;

  // low count bits chosen by select must all be ones for a pass
  always_comb begin
    case (select)
      2'b00: mask = 3'h0;
      2'b01: mask = 3'h1;
      2'b10: mask = 3'h3;
      2'b11: mask = 3'h7;
      default: mask = 3'h0;
    endcase
  end

  assign out_tick = tick && ((cnt_reg & mask) == mask);

  // hidden count, cleared by counter writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
    end else if (clear) begin
      cnt_reg <= 3'h0;
    end else if (tick) begin
      cnt_reg <= (out_tick) ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_clear_zero;
    clear |=> (cnt_reg == 3'h0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("prescale not cleared");

  property p_div8;
    (select == 2'b11) && tick && !clear && (cnt_reg == 3'h6) |-> !out_tick;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight passed early");
endmodule : gst_prescaler
`default_nettype wire

// ---- design/gst_sync.sv ----
// three-flop synchroniser with agreement filter for one pin level
// assumes the input is asynchronous to clk; output is a clean level
`timescale 1ns/1ps
`default_nettype none
module gst_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // capture chain, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level changes once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      dout <= s3_reg;
    end
  end
endmodule : gst_sync
`default_nettype wire

// ---- design/gst_timer.sv ----
// sixteen bit gated timer with axi4-lite register port
// assumes pins and comparator level are asynchronous; aclk is fosc
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - count is sixteen bits in two bytes; byte writes replace that byte at once
// - source select clear counts instruction clock, set counts the external input
// - external input counts on its rising edges only
// - sync disable set counts edges at once, clear aligns them to instruction clock
// - a falling edge must be seen before the first rising edge after listed events
// - prescaler divides by 1, 2, 4 or 8; its count is hidden
// - any counter byte write clears the prescale count
// - oscillator enable starts the crystal, which keeps running in sleep
// - crystal clock usable only with internal or low power primary clock
// - crystal enabled forces pin 5 and 4 to inputs; data reads 0, direction 1
// - asynchronous counter mode keeps counting in sleep and overflow can wake
// - mode change may drop or add one count
// - count reads while counting asynchronously return one byte per read; the other byte is not latched
// - gate source is the gate pin or comparator b output
// - gating acts only with gate enable set
// - gate invert inverts the gate for either source
// - count rolls from all ones to zero and sets the overflow flag
// - prescale field 11 is 1:8, 10 is 1:4, 01 is 1:2, 00 is 1:1
module gst_timer
  import gst_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_in,
  input wire logic gate_pin,
  input wire logic comparator_b_output,
  input wire logic low_power_crystal_clock,
  input wire logic primary_clock_lp_ok,
  input wire logic sleep_mode,
  output logic crystal_osc_run,
  output logic pin5_direction,
  output logic pin4_direction,
  output logic overflow_flag,
  output logic wake_request
);
  logic [7:0] ctrl_reg;
  logic gate_source_select_reg;
  logic [1:0] port_dir_reg;
  logic [15:0] count_reg;
  logic [1:0] inst_div_reg;
  logic ext_prev_reg;
  logic armed_reg;
  logic pend_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic wr_strb0_reg;
  logic ext_s;
  logic gate_s;
  logic comp_s;
  logic xtal_s;

  // pin and comparator levels into the aclk domain
  gst_sync u_sync_ext (.clk(aclk), .rst_n(aresetn), .din(ext_clock_in), .dout(ext_s));
  gst_sync u_sync_gate (.clk(aclk), .rst_n(aresetn), .din(gate_pin), .dout(gate_s));
  gst_sync u_sync_comp (.clk(aclk), .rst_n(aresetn), .din(comparator_b_output), .dout(comp_s));
  gst_sync u_sync_xtal (.clk(aclk), .rst_n(aresetn), .din(low_power_crystal_clock), .dout(xtal_s));

  // control fields
  logic timer_on;
  logic clock_source_select;
  logic sync_disable;
  logic crystal_osc_enable;
  logic [1:0] prescale_select;
  logic gate_enable;
  logic gate_invert;
  assign timer_on = ctrl_reg[GST_B_TIMER_ON];
  assign clock_source_select = ctrl_reg[GST_B_CLK_SEL];
  assign sync_disable = ctrl_reg[GST_B_SYNC_DIS];
  assign crystal_osc_enable = ctrl_reg[GST_B_OSC_EN];
  assign prescale_select = ctrl_reg[GST_B_PSC_LO +: 2];
  assign gate_enable = ctrl_reg[GST_B_GATE_EN];
  assign gate_invert = ctrl_reg[GST_B_GATE_INV];

  // write channel: address and data held until both are in
  logic wr_fire;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_stat;
  logic wr_gsrc;
  logic wr_port;
  logic cnt_write;
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && wr_strb0_reg && (wr_addr_reg == GST_ADDR_CTRL);
  assign wr_lo = wr_fire && wr_strb0_reg && (wr_addr_reg == GST_ADDR_CNT_LO);
  assign wr_hi = wr_fire && wr_strb0_reg && (wr_addr_reg == GST_ADDR_CNT_HI);
  assign wr_stat = wr_fire && wr_strb0_reg && (wr_addr_reg == GST_ADDR_STATUS);
  assign wr_gsrc = wr_fire && wr_strb0_reg && (wr_addr_reg == GST_ADDR_GATE_SRC);
  assign wr_port = wr_fire && wr_strb0_reg && (wr_addr_reg == GST_ADDR_PORT);
  assign cnt_write = wr_lo || wr_hi;
  assign wr_ok = (wr_addr_reg == GST_ADDR_CTRL) || (wr_addr_reg == GST_ADDR_CNT_LO)
              || (wr_addr_reg == GST_ADDR_CNT_HI) || (wr_addr_reg == GST_ADDR_STATUS)
              || (wr_addr_reg == GST_ADDR_GATE_SRC) || (wr_addr_reg == GST_ADDR_PORT);

  // write handshake, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GST_RESP_OKAY;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 32'h0000_0000;
      wr_strb0_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_reg <= s_axi_wdata;
        wr_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? GST_RESP_OKAY : GST_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // software control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= GST_CTRL_RST;
      gate_source_select_reg <= GST_GATE_SRC_RST;
      port_dir_reg <= {GST_DIR_RST, GST_DIR_RST};
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wr_data_reg[7:0];
      end
      if (wr_gsrc) begin
        gate_source_select_reg <= wr_data_reg[GST_B_GATE_SRC];
      end
      if (wr_port) begin
        port_dir_reg <= {wr_data_reg[GST_B_PIN5_DIR], wr_data_reg[GST_B_PIN4_DIR]};
      end
    end
  end

  // crystal runs only where it may share the low power oscillator
  logic xtal_usable;
  assign xtal_usable = crystal_osc_enable && primary_clock_lp_ok;

  // crystal drive and forced pin directions, independent of sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_osc_run <= 1'b0;
      pin5_direction <= GST_DIR_RST;
      pin4_direction <= GST_DIR_RST;
    end else begin
      crystal_osc_run <= xtal_usable;
      pin5_direction <= crystal_osc_enable | port_dir_reg[1];
      pin4_direction <= crystal_osc_enable | port_dir_reg[0];
    end
  end

  // instruction clock enable, fosc divided by four, stopped in sleep
  logic inst_tick;
  assign inst_tick = (inst_div_reg == GST_INST_LAST) && !sleep_mode;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inst_div_reg <= 2'h0;
    end else begin
      inst_div_reg <= inst_div_reg + 2'h1;
    end
  end

  // gate selection, inversion and enable
  logic gate_level;
  logic gate_active;
  logic run;
  assign gate_level = gate_source_select_reg ? comp_s : gate_s;
  assign gate_active = gate_invert ? gate_level : !gate_level;
  assign run = timer_on && (!gate_enable || gate_active);

  // external edge detection on the selected input
  logic ext_sel;
  logic ext_rise;
  logic ext_fall;
  logic rise_ok;
  assign ext_sel = xtal_usable ? xtal_s : ext_s;
  assign ext_rise = ext_sel && !ext_prev_reg;
  assign ext_fall = !ext_sel && ext_prev_reg;
  assign rise_ok = ext_rise && armed_reg && run;

  // previous level and falling edge arming
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_sel;
      if (cnt_write) begin
        armed_reg <= 1'b0;
      end else if (ext_fall) begin
        armed_reg <= timer_on;
      end
    end
  end

  // synchronous mode holds an edge until the next instruction tick
  logic sync_tick;
  assign sync_tick = inst_tick && (pend_reg || rise_ok);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 1'b0;
    end else if (cnt_write || !clock_source_select || sync_disable) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= !inst_tick && (pend_reg || rise_ok);
    end
  end

  // source selection into the prescaler
  logic src_tick;
  logic psc_tick;
  logic inc;
  always_comb begin
    if (!clock_source_select) begin
      src_tick = inst_tick;
    end else if (sync_disable) begin
      src_tick = rise_ok;
    end else begin
      src_tick = sync_tick;
    end
  end
  assign psc_tick = src_tick && run && !cnt_write;

  gst_prescaler u_psc (
    .clk(aclk),
    .rst_n(aresetn),
    .tick(psc_tick),
    .clear(cnt_write),
    .select(prescale_select),
    .out_tick(inc)
  );

  // count register: byte writes win over increments
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= GST_CNT_ZERO;
    end else if (wr_lo) begin
      count_reg[7:0] <= wr_data_reg[7:0];
    end else if (wr_hi) begin
      count_reg[15:8] <= wr_data_reg[7:0];
    end else if (inc) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // overflow flag, set beats a software clear; wake pulse in sleep
  logic ovf_evt;
  assign ovf_evt = inc && (count_reg == GST_CNT_MAX);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      if (ovf_evt) begin
        overflow_flag <= 1'b1;
      end else if (wr_stat && wr_data_reg[GST_B_OVF]) begin
        overflow_flag <= 1'b0;
      end
      wake_request <= ovf_evt && sleep_mode;
    end
  end

  // read data mux, pin data forced low with the crystal on
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      GST_ADDR_CTRL: rd_mux[7:0] = ctrl_reg;
      GST_ADDR_CNT_LO: rd_mux[7:0] = count_reg[7:0];
      GST_ADDR_CNT_HI: rd_mux[7:0] = count_reg[15:8];
      GST_ADDR_STATUS: rd_mux[GST_B_OVF] = overflow_flag;
      GST_ADDR_GATE_SRC: rd_mux[GST_B_GATE_SRC] = gate_source_select_reg;
      GST_ADDR_PORT: begin
        rd_mux[GST_B_PIN5_DIR] = crystal_osc_enable | port_dir_reg[1];
        rd_mux[GST_B_PIN4_DIR] = crystal_osc_enable | port_dir_reg[0];
        rd_mux[GST_B_PIN5_DATA] = ext_s && !crystal_osc_enable;
        rd_mux[GST_B_PIN4_DATA] = gate_s && !crystal_osc_enable;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // read handshake, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= GST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? GST_RESP_OKAY : GST_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_low;
    wr_lo |=> (count_reg[7:0] == $past(wr_data_reg[7:0])) && $stable(count_reg[15:8]);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low byte write lost");

  property p_hold_off;
    !timer_on && !cnt_write |=> $stable(count_reg);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while off");

  property p_rollover;
    inc && (count_reg == GST_CNT_MAX) && !cnt_write
      |=> (count_reg == GST_CNT_ZERO) && overflow_flag;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover wrong");

  property p_dir_forced;
    crystal_osc_enable ##1 crystal_osc_enable |-> pin5_direction && pin4_direction;
  endproperty
  a_dir_forced: assert property (p_dir_forced) else $error("pin direction not forced");

  property p_arm_clear;
    cnt_write |=> !armed_reg;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("write left counter armed");

  property p_gate_block;
    gate_enable && !gate_active |-> !psc_tick;
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("tick through closed gate");

  property p_sync_align;
    clock_source_select && !sync_disable && psc_tick |-> inst_tick;
  endproperty
  a_sync_align: assert property (p_sync_align) else $error("sync tick off phase");

  property p_internal_rate;
    !clock_source_select && psc_tick |-> ##1 !psc_tick [*3];
  endproperty
  a_internal_rate: assert property (p_internal_rate) else $error("fast internal tick");

  property p_wake;
    ovf_evt && sleep_mode |=> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on overflow");
endmodule : gst_timer
`default_nettype wire

// ---- dv/gst_far_src.sv ----
// far side model: external count clock in bursts and a crystal clock
// assumes the bench pulses burst_go for one aclk cycle with burst_len set
`timescale 1ns/1ps
`default_nettype none
module gst_far_src (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic burst_go,
  input wire logic [7:0] burst_len,
  input wire logic [3:0] half_cyc,
  input wire logic osc_run,
  output logic ext_clk,
  output logic xtal_clk,
  output logic busy
);
  logic [7:0] left_reg;
  logic [3:0] ph_reg;
  logic [2:0] xdiv_reg;
  // pulse bursts; line parked low between bursts, so no free edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_clk <= 1'b0;
      left_reg <= 8'h00;
      ph_reg <= 4'h0;
    end else if (burst_go && left_reg == 8'h00) begin
      left_reg <= burst_len;
      ph_reg <= 4'h0;
    end else if (left_reg != 8'h00) begin
      if (ph_reg == half_cyc - 4'h1) begin
        ph_reg <= 4'h0;
        ext_clk <= !ext_clk;
        if (ext_clk) begin
          left_reg <= left_reg - 8'h01; // a pulse ends on its fall
        end
      end else begin
        ph_reg <= ph_reg + 4'h1;
      end
    end
  end
  // crystal swings only while its oscillator is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !osc_run) begin
      xtal_clk <= 1'b0;
      xdiv_reg <= 3'h0;
    end else begin
      xdiv_reg <= xdiv_reg + 3'h1;
      if (xdiv_reg == 3'h7) begin
        xtal_clk <= !xtal_clk;
      end
    end
  end
  assign busy = (left_reg != 8'h00);
endmodule : gst_far_src
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the gated timer over its axi4-lite port
// assumes the design package is compiled first; clock 50 MHz
`timescale 1ns/1ps
`default_nettype none
module tb import gst_pkg::*; ;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, burst_len;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic gate_pin, comparator_b_output, primary_clock_lp_ok, sleep_mode, lvl;
  logic ext_clock_in, low_power_crystal_clock, crystal_osc_run, burst_go, far_busy;
  logic pin5_direction, pin4_direction, overflow_flag, wake_request, wake_seen;
  logic [31:0] d0, d1;
  logic [1:0] r0;
  int error_cnt, checked, s, v, g;
  gst_timer u_gst_timer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_clock_in(ext_clock_in),
    .gate_pin(gate_pin), .comparator_b_output(comparator_b_output),
    .low_power_crystal_clock(low_power_crystal_clock),
    .primary_clock_lp_ok(primary_clock_lp_ok), .sleep_mode(sleep_mode),
    .crystal_osc_run(crystal_osc_run), .pin5_direction(pin5_direction),
    .pin4_direction(pin4_direction), .overflow_flag(overflow_flag),
    .wake_request(wake_request));
  gst_far_src u_gst_far_src (.aclk(aclk), .aresetn(aresetn), .burst_go(burst_go),
    .burst_len(burst_len), .half_cyc(4'd6), .osc_run(crystal_osc_run),
    .ext_clk(ext_clock_in), .xtal_clk(low_power_crystal_clock), .busy(far_busy));
  // free-running clock, 20 ns period
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // remember any wake pulse
  always @(posedge aclk) if (wake_request === 1'b1) wake_seen <= 1'b1;
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic hang;
    error_cnt++;
    complete_run();
  endtask : hang
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    checked++;
    if (got !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  // one axi write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 64) hang(); // bready stays high between writes
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  // one axi read; data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n == 64) hang(); // rready stays high between reads
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] er);
    rd(a, d0, r0);
    chk(nm, {24'h0, e}, d0);
    chk("rresp", {30'h0, er}, {30'h0, r0});
  endtask : rchk
  task automatic cnt_chk(input logic [15:0] e);
    rchk("count_low_byte", GST_ADDR_CNT_LO, e[7:0], GST_RESP_OKAY);
    rchk("count_high_byte", GST_ADDR_CNT_HI, e[15:8], GST_RESP_OKAY);
  endtask : cnt_chk
  // stop the timer, then clear both count bytes
  task automatic zero;
    wr(GST_ADDR_CTRL, 8'h00, GST_RESP_OKAY);
    wr(GST_ADDR_CNT_LO, 8'h00, GST_RESP_OKAY);
    wr(GST_ADDR_CNT_HI, 8'h00, GST_RESP_OKAY);
  endtask : zero
  task automatic burst(input logic [7:0] n);
    int k;
    burst_len <= n;
    burst_go <= 1'b1;
    @(posedge aclk);
    burst_go <= 1'b0;
    for (k = 0; k < 4000; k++) begin
      @(posedge aclk);
      if (!far_busy) break;
    end
    if (k == 4000) hang();
    repeat (24) @(posedge aclk);
  endtask : burst
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, burst_len, burst_go} = '0;
    {gate_pin, comparator_b_output, sleep_mode, wake_seen, error_cnt, checked} = '0;
    s_axi_wstrb = 4'hf;
    primary_clock_lp_ok = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("ctrl", GST_ADDR_CTRL, GST_CTRL_RST, GST_RESP_OKAY);
    rchk("gate_src", GST_ADDR_GATE_SRC, 8'h02, GST_RESP_OKAY);
    rchk("port", GST_ADDR_PORT, 8'h30, GST_RESP_OKAY);
    rchk("unmapped", 8'h18, 8'h00, GST_RESP_SLVERR);
    wr(8'h18, 8'h5a, GST_RESP_SLVERR);
    cnt_chk(16'h0000);
    wr(GST_ADDR_CNT_LO, 8'h34, GST_RESP_OKAY);
    wr(GST_ADDR_CNT_HI, 8'h12, GST_RESP_OKAY);
    wr(GST_ADDR_CNT_HI, 8'hab, GST_RESP_OKAY);
    cnt_chk(16'hab34);
    // byte lane 0 off: write answered but ignored
    s_axi_wstrb <= 4'he;
    wr(GST_ADDR_CNT_LO, 8'h77, GST_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    cnt_chk(16'hab34);
    // instruction clock: one count per four aclk at 1:1
    zero();
    wr(GST_ADDR_CTRL, 8'h01, GST_RESP_OKAY);
    repeat (400) @(posedge aclk);
    wr(GST_ADDR_CTRL, 8'h00, GST_RESP_OKAY);
    rd(GST_ADDR_CNT_LO, d0, r0);
    chk("internal_rate", 32'h1, 32'(d0 >= 95 && d0 <= 106));
    repeat (100) @(posedge aclk);
    rd(GST_ADDR_CNT_LO, d1, r0);
    chk("count_held", d0, d1);
    // 20 pulses after a count write: first rise unarmed, 19 prescaled
    for (s = 0; s < 2; s++) begin
      for (v = 0; v < 4; v++) begin
        zero();
        wr(GST_ADDR_CTRL, 8'(8'h03 | (s << 2) | (v << 4)), GST_RESP_OKAY);
        burst(8'd20);
        cnt_chk(16'(19 >> v));
      end
    end
    // gate source, polarity and enable; g=1 drives the inactive level
    for (s = 0; s < 2; s++) begin
      for (v = 0; v < 2; v++) begin
        for (g = 0; g < 2; g++) begin
          lvl = 1'(v ^ g);
          gate_pin <= (s == 0) ? lvl : !lvl;
          comparator_b_output <= (s == 1) ? lvl : !lvl;
          zero();
          wr(GST_ADDR_GATE_SRC, 8'(s << 1), GST_RESP_OKAY);
          wr(GST_ADDR_CTRL, 8'(8'h47 | (v << 7)), GST_RESP_OKAY);
          burst(8'd9);
          cnt_chk((g == 0) ? 16'h0008 : 16'h0000);
        end
      end
    end
    zero();
    wr(GST_ADDR_CTRL, 8'h07, GST_RESP_OKAY);
    burst(8'd9);
    cnt_chk(16'h0008);
    // rollover in sleep, asynchronous counting
    zero();
    wr(GST_ADDR_CNT_LO, 8'hfe, GST_RESP_OKAY);
    wr(GST_ADDR_CNT_HI, 8'hff, GST_RESP_OKAY);
    wr(GST_ADDR_CTRL, 8'h07, GST_RESP_OKAY);
    sleep_mode <= 1'b1;
    burst(8'd3);
    sleep_mode <= 1'b0;
    chk("wake_request", 32'h1, {31'h0, wake_seen});
    chk("overflow_flag", 32'h1, {31'h0, overflow_flag});
    cnt_chk(16'h0000);
    rchk("status", GST_ADDR_STATUS, 8'h01, GST_RESP_OKAY);
    wr(GST_ADDR_STATUS, 8'h01, GST_RESP_OKAY);
    rchk("status", GST_ADDR_STATUS, 8'h00, GST_RESP_OKAY);
    // crystal enable forces both pins to inputs, data reads 0
    wr(GST_ADDR_CTRL, 8'h00, GST_RESP_OKAY);
    wr(GST_ADDR_PORT, 8'h00, GST_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("pin_dirs", 32'h0, {30'h0, pin5_direction, pin4_direction});
    gate_pin <= 1'b1;
    wr(GST_ADDR_CTRL, 8'h08, GST_RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("crystal_osc_run", 32'h1, {31'h0, crystal_osc_run});
    chk("pin_dirs", 32'h3, {30'h0, pin5_direction, pin4_direction});
    rchk("port", GST_ADDR_PORT, 8'h30, GST_RESP_OKAY);
    // crystal as count source, timer on only after it has run a while
    wr(GST_ADDR_CNT_LO, 8'h00, GST_RESP_OKAY);
    wr(GST_ADDR_CNT_HI, 8'h00, GST_RESP_OKAY);
    wr(GST_ADDR_CTRL, 8'h0f, GST_RESP_OKAY);
    repeat (320) @(posedge aclk);
    wr(GST_ADDR_CTRL, 8'h08, GST_RESP_OKAY);
    rd(GST_ADDR_CNT_LO, d0, r0);
    chk("crystal_count", 32'h1, 32'(d0 >= 18 && d0 <= 21));
    primary_clock_lp_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("crystal_osc_run", 32'h0, {31'h0, crystal_osc_run});
    complete_run();
  end
endmodule : tb
`default_nettype wire
